/* File: hdl/timer2_pkg.sv */
package timer2_pkg;

  // register offsets on the special function bus
  localparam logic [7:0] OFF_CONTROL      = 8'hC8;
  localparam logic [7:0] OFF_MODE_CONTROL = 8'hC9;
  localparam logic [7:0] OFF_CAPTURE_LOW  = 8'hCA;
  localparam logic [7:0] OFF_CAPTURE_HIGH = 8'hCB;
  localparam logic [7:0] OFF_COUNT_LOW    = 8'hCC;
  localparam logic [7:0] OFF_COUNT_HIGH   = 8'hCD;

  // control register bit positions
  localparam int BIT_OVERFLOW    = 7;
  localparam int BIT_EXT_EDGE    = 6;
  localparam int BIT_RX_BAUD_SEL = 5;
  localparam int BIT_TX_BAUD_SEL = 4;
  localparam int BIT_EXT_TRIG_EN = 3;
  localparam int BIT_RUN         = 2;
  localparam int BIT_COUNT_SRC   = 1;
  localparam int BIT_CAP_REL     = 0;

  // mode control bit positions
  localparam int BIT_CAP_CLEAR   = 3;
  localparam int BIT_CLK_OUT_EN  = 1;
  localparam int BIT_DOWN_EN     = 0;
  localparam logic [7:0] MODE_WRITE_MASK = 8'h0B;

  // reset values and full count
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // baud mode ticks every two clocks; slow timer tick divider
  localparam logic [0:0] BAUD_DIV_RST  = 1'b0;
  localparam int         SLOW_TICK_DIV = 12;
  localparam logic [3:0] SLOW_DIV_LAST = 4'hB;
  localparam logic [3:0] SLOW_DIV_RST  = 4'h0;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;

  typedef struct packed {
    logic overflowFlag;
    logic extEdgeFlag;
    logic rxBaudSel;
    logic txBaudSel;
    logic extTriggerEnable;
    logic runControl;
    logic countSourceSel;
    logic captureReloadSel;
  } control_s;

  typedef struct packed {
    control_s    ctrl;
    logic [7:0]  mode;
    logic [15:0] reloadCapture;
    logic [15:0] count;
    logic        baudPhase;
    logic [3:0]  slowDiv;
    logic [1:0]  trigSync;
    logic        trigLast;
    logic [1:0]  cntSync;
    logic        cntLast;
    logic        clockOut;
    logic [7:0]  rdata;
  } state_s;

endpackage : timer2_pkg

/* File: hdl/capture_reload_baud_timer.sv */
`timescale 1ns/1ps
// Function
// - overflow or down-count match sets overflow flag
// - hardware sets overflow only with baud selects clear
// - trigger fall or down-count overflow sets edge flag
// - edge flag software cleared; raises interrupt request
// - receive baud select picks this timer's overflows
// - transmit baud select picks this timer's overflows
// - trigger pin falls ignored unless enabled, not baud
// - run control starts, stops, holds count
// - source select: internal ticks or pin falls
// - baud mode counts every two clocks
// - baud selects force reload after overflow
// - reload mode reloads on up-count overflow, trigger fall
// - capture mode copies count on trigger fall
// - capture auto-clear zeroes count after capture
// - clock-out enable switches clock output
// - down enable with pin sets direction
// - low capture byte captures, supplies reload low
// - high capture byte captures, supplies reload high
module capture_reload_baud_timer (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire timer2_pkg::bus_req_s busReq,
  output logic [7:0]             busRdata,
  input  wire logic              extTriggerPin,
  input  wire logic              extCountPin,
  input  wire logic              tickRateSel,
  output logic                   timerIrq,
  output logic                   rxBaudTick,
  output logic                   txBaudTick,
  output logic                   rxBaudFromTimer,
  output logic                   txBaudFromTimer,
  output logic                   clockOutValue,
  output logic                   clockOutEnable
);
  import timer2_pkg::*;

  state_s q;
  state_s d;

  logic baudMode;
  logic trigFall;
  logic cntFall;
  logic tick;
  logic downMode;
  logic overflow;
  logic edgeWrite;
  logic [15:0] nextCount;
  logic [15:0] reloadValue;

  // decoded modes and edge detectors
  always_comb begin
    baudMode    = q.ctrl.rxBaudSel | q.ctrl.txBaudSel;
    trigFall    = q.trigLast & ~q.trigSync[1] & q.ctrl.extTriggerEnable
                  & ~baudMode;
    cntFall     = q.cntLast & ~q.cntSync[1];
    downMode    = q.mode[BIT_DOWN_EN] & ~q.ctrl.captureReloadSel & ~baudMode
                  & ~q.trigSync[1];
    reloadValue = q.reloadCapture;
    edgeWrite   = busReq.wr && busReq.addr == OFF_CONTROL && busReq.wdata[BIT_EXT_EDGE];
    // tick select
    if (!q.ctrl.runControl) begin
      tick = 1'b0;
    end else if (baudMode) begin
      tick = q.baudPhase;
    end else if (q.ctrl.countSourceSel) begin
      tick = cntFall;
    end else begin
      tick = tickRateSel ? 1'b1 : (q.slowDiv == SLOW_DIV_LAST);
    end
    if (downMode) begin
      overflow  = tick && q.count == reloadValue;
      nextCount = overflow ? COUNT_MAX : q.count - 16'h0001;
    end else begin
      overflow  = tick && q.count == COUNT_MAX;
      nextCount = q.count + 16'h0001;
    end
  end

  // next state
  always_comb begin
    d = q;
    d.rdata    = RST_BYTE;
    d.trigSync = {q.trigSync[0], extTriggerPin};
    d.trigLast = q.trigSync[1];
    d.cntSync  = {q.cntSync[0], extCountPin};
    d.cntLast  = q.cntSync[1];
    d.baudPhase = baudMode ? ~q.baudPhase : BAUD_DIV_RST;
    d.slowDiv   = (q.slowDiv == SLOW_DIV_LAST) ? SLOW_DIV_RST : q.slowDiv + 4'h1;

    // count update
    if (tick) begin
      if (overflow && (baudMode || !q.ctrl.captureReloadSel) && !downMode) begin
        d.count = reloadValue;
      end else begin
        d.count = nextCount;
      end
      if (overflow && baudMode) begin
        d.clockOut = ~q.clockOut;
      end
    end
    if (trigFall && !q.ctrl.captureReloadSel) begin
      d.count = reloadValue;
    end
    if (trigFall && q.ctrl.captureReloadSel) begin
      d.reloadCapture = q.count;
      if (q.mode[BIT_CAP_CLEAR]) begin
        d.count = RST_WORD;
      end
    end

    // register writes
    if (busReq.wr) begin
      unique case (busReq.addr)
        OFF_CONTROL:      d.ctrl = control_s'(busReq.wdata);
        OFF_MODE_CONTROL: d.mode = busReq.wdata & MODE_WRITE_MASK;
        OFF_CAPTURE_LOW:  d.reloadCapture[7:0] = busReq.wdata;
        OFF_CAPTURE_HIGH: d.reloadCapture[15:8] = busReq.wdata;
        OFF_COUNT_LOW:    d.count[7:0] = busReq.wdata;
        OFF_COUNT_HIGH:   d.count[15:8] = busReq.wdata;
        default: ;
      endcase
    end

    // hardware flag sets win over software clears
    if (overflow && !baudMode) begin
      d.ctrl.overflowFlag = 1'b1;
    end
    if (trigFall || (overflow && downMode)) begin
      d.ctrl.extEdgeFlag = 1'b1;
    end

    // reads
    if (busReq.rd) begin
      unique case (busReq.addr)
        OFF_CONTROL:      d.rdata = q.ctrl;
        OFF_MODE_CONTROL: d.rdata = q.mode;
        OFF_CAPTURE_LOW:  d.rdata = q.reloadCapture[7:0];
        OFF_CAPTURE_HIGH: d.rdata = q.reloadCapture[15:8];
        OFF_COUNT_LOW:    d.rdata = q.count[7:0];
        OFF_COUNT_HIGH:   d.rdata = q.count[15:8];
        default:          d.rdata = RST_BYTE;
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // outputs
  assign busRdata        = q.rdata;
  assign timerIrq        = q.ctrl.overflowFlag | q.ctrl.extEdgeFlag | edgeWrite;
  assign rxBaudFromTimer = q.ctrl.rxBaudSel;
  assign txBaudFromTimer = q.ctrl.txBaudSel;
  assign rxBaudTick      = overflow & q.ctrl.rxBaudSel;
  assign txBaudTick      = overflow & q.ctrl.txBaudSel;
  assign clockOutEnable  = q.mode[BIT_CLK_OUT_EN];
  assign clockOutValue   = q.clockOut & q.mode[BIT_CLK_OUT_EN];

endmodule : capture_reload_baud_timer

/* File: dv/timer2_monitor.sv */
`timescale 1ns/1ps
// watches the register bus and baud outputs
module timer2_monitor (
  input wire logic                 sys_clk,
  input wire logic                 resetn,
  input wire timer2_pkg::bus_req_s busReq,
  input wire logic [7:0]           busRdata,
  input wire logic                 rxBaudTick,
  input wire logic                 txBaudTick,
  input wire logic                 rxBaudFromTimer,
  input wire logic                 txBaudFromTimer,
  input wire logic                 clockOutEnable
);
  import timer2_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // select bits follow control writes
  a_rx_sel_write: assert property (busReq.wr && busReq.addr == OFF_CONTROL
    |=> rxBaudFromTimer == $past(busReq.wdata[BIT_RX_BAUD_SEL])) else $error("rx select");
  a_tx_sel_write: assert property (busReq.wr && busReq.addr == OFF_CONTROL
    |=> txBaudFromTimer == $past(busReq.wdata[BIT_TX_BAUD_SEL])) else $error("tx select");
  // ticks only reach the port when selected
  a_rx_tick_sel: assert property (rxBaudTick |-> rxBaudFromTimer) else $error("rx tick");
  a_tx_tick_sel: assert property (txBaudTick |-> txBaudFromTimer) else $error("tx tick");
  // baud count steps at most every two clocks
  a_rx_tick_gap: assert property (rxBaudTick |=> !rxBaudTick) else $error("rx gap");
  a_tx_tick_gap: assert property (txBaudTick |=> !txBaudTick) else $error("tx gap");
  a_tick_pair: assert property (rxBaudTick && txBaudFromTimer |-> txBaudTick)
    else $error("tick pair");
  a_clkout_write: assert property (busReq.wr && busReq.addr == OFF_MODE_CONTROL
    |=> clockOutEnable == $past(busReq.wdata[BIT_CLK_OUT_EN])) else $error("clock out");
endmodule : timer2_monitor
bind capture_reload_baud_timer timer2_monitor i_mon (.sys_clk(sys_clk), .resetn(resetn),
  .busReq(busReq), .busRdata(busRdata), .rxBaudTick(rxBaudTick), .txBaudTick(txBaudTick),
  .rxBaudFromTimer(rxBaudFromTimer), .txBaudFromTimer(txBaudFromTimer),
  .clockOutEnable(clockOutEnable));

/* File: dv/pin_partner.sv */
`timescale 1ns/1ps
// far-side trigger and count pins, pulled high when idle
module pin_partner (
  input  wire logic sys_clk,
  output logic      trigPin,
  output logic      cntPin
);
  initial begin
    trigPin = 1'b1;
    cntPin  = 1'b1;
  end
  // one falling edge, held low long enough to sync
  task automatic fall(input logic sel);
    @(posedge sys_clk);
    if (sel) cntPin <= 1'b0; else trigPin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    cntPin  <= 1'b1;
    trigPin <= 1'b1;
  endtask : fall
  // steady trigger level, used as count direction
  task automatic level(input logic v);
    @(posedge sys_clk);
    trigPin <= v;
  endtask : level
endmodule : pin_partner

/* File: dv/tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin miscompares++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb;
  import timer2_pkg::*;
  logic       sys_clk = 0, resetn = 0, tickRateSel = 1, trig, cnt, rxT;
  logic       txT, irq, coVal, coEn, coLast = 0;
  int         txTicks = 0, coEdges = 0;
  bus_req_s   req = '0;
  logic [7:0] rdata;
  int         miscompares = 0, numChecks = 0, cyc = 0, ticks = 0;
  logic [23:0] rows [7] = '{24'hCA5A5A, 24'hCBA5A5, 24'hC9F202, 24'hC80909,
                            24'hCC3434, 24'hCD1212, 24'hC0FF00};
  pin_partner pp (.sys_clk(sys_clk), .trigPin(trig), .cntPin(cnt));
  capture_reload_baud_timer i_dut (.sys_clk(sys_clk), .resetn(resetn), .busReq(req),
    .busRdata(rdata), .extTriggerPin(trig), .extCountPin(cnt), .tickRateSel(tickRateSel),
    .timerIrq(irq), .rxBaudTick(rxT), .txBaudTick(txT), .rxBaudFromTimer(),
    .txBaudFromTimer(), .clockOutValue(coVal), .clockOutEnable(coEn));
  // combinational ticks sampled mid-cycle, away from the launching edge
  always @(negedge sys_clk) begin
    if (rxT) ticks++;
    if (txT) txTicks++;
    if (coVal !== coLast) coEdges++;
    coLast = coVal;
  end
  // clock, tick counter and hang limit
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk) req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk) req.rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask : rd
  task automatic print_verdict();
    $display("miscompares=%0d checks=%0d", miscompares, numChecks);
    if (miscompares == 0 && numChecks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // register rows, then pin, counter, reload and baud cases
  initial begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(OFF_CONTROL, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    pp.fall(1'b0);
    repeat (4) @(posedge sys_clk);
    rd(OFF_CAPTURE_LOW, 8'h34);
    rd(OFF_CAPTURE_HIGH, 8'h12);
    rd(OFF_CONTROL, 8'h49);
    `CHK(irq, 1'b1)
    rd(OFF_COUNT_LOW, 8'h34);
    wr(OFF_CONTROL, 8'h02);
    wr(OFF_COUNT_LOW, 8'h00);
    wr(OFF_COUNT_HIGH, 8'h00);
    wr(OFF_CONTROL, 8'h06);
    repeat (3) pp.fall(1'b1);
    wr(OFF_CONTROL, 8'h02);
    rd(OFF_COUNT_LOW, 8'h03);
    wr(OFF_CAPTURE_LOW, 8'h10);
    wr(OFF_CAPTURE_HIGH, 8'h00);
    wr(OFF_COUNT_LOW, 8'hFE);
    wr(OFF_COUNT_HIGH, 8'hFF);
    wr(OFF_CONTROL, 8'h04);
    repeat (8) @(posedge sys_clk);
    rd(OFF_CONTROL, 8'h84);
    wr(OFF_CONTROL, 8'h80);
    rd(OFF_COUNT_HIGH, 8'h00);
    wr(OFF_CAPTURE_LOW, 8'hFE);
    wr(OFF_CAPTURE_HIGH, 8'hFF);
    wr(OFF_COUNT_HIGH, 8'hFF);
    wr(OFF_COUNT_LOW, 8'hFE);
    wr(OFF_CONTROL, 8'h34);
    repeat (10) @(posedge sys_clk);
    #1 ticks = 0;
    txTicks = 0;
    coEdges = 0;
    repeat (40) @(posedge sys_clk);
    #1 `CHK(ticks, 10)
    `CHK(txTicks, 10)
    `CHK(coEdges, 10)
    `CHK(coEn, 1'b1)
    rd(OFF_CONTROL, 8'h34);
    // down count with pin low: match on reload wraps to all ones
    wr(OFF_CONTROL, 8'h00);
    pp.level(1'b0);
    wr(OFF_MODE_CONTROL, 8'h01);
    wr(OFF_CAPTURE_LOW, 8'h05);
    wr(OFF_CAPTURE_HIGH, 8'h00);
    wr(OFF_COUNT_LOW, 8'h07);
    wr(OFF_COUNT_HIGH, 8'h00);
    wr(OFF_CONTROL, 8'h04);
    repeat (4) @(posedge sys_clk);
    rd(OFF_CONTROL, 8'hC4);
    rd(OFF_COUNT_HIGH, 8'hFF);
    // capture with auto-clear zeroes the count
    wr(OFF_CONTROL, 8'h00);
    pp.level(1'b1);
    wr(OFF_MODE_CONTROL, 8'h08);
    wr(OFF_COUNT_LOW, 8'h44);
    wr(OFF_COUNT_HIGH, 8'h00);
    wr(OFF_CONTROL, 8'h09);
    pp.fall(1'b0);
    repeat (4) @(posedge sys_clk);
    rd(OFF_CAPTURE_LOW, 8'h44);
    rd(OFF_COUNT_LOW, 8'h00);
    print_verdict();
  end
endmodule : tb
